// ---- verilog/ubd_baud_gen.v ----
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ubd_defs.vh"

// Functional notes
// R1 - Software writes high half, then low half
// R2 - High write buffers; low write commits divisor
// R3 - Divisor is high[4:0] joined with low[7:0]
// R4 - Zero divisor stops the generator
// R5 - Bit rate is clock over sixteen times divisor
// R6 - Idle after reset until rx/tx first enabled
// R7 - Count modulo divisor; reload on new divisor
module ubd_baud_gen
(
	input  wire                   I_CORE_CLK,
	input  wire                   I_RST_N,
	input  wire [`UBD_ADDR_W-1:0] I_ADDR,
	input  wire [7:0]             I_WDATA,
	input  wire                   I_WR,
	input  wire                   I_RD,
	output reg  [7:0]             O_RDATA,
	output reg                    O_TICK16,
	output reg                    O_BIT_TICK,
	output reg                    O_RX_ON,
	output reg                    O_TX_ON
);

	wire [4:0]  high_buf;
	wire [12:0] divisor;
	wire [7:0]  ctrl;
	wire        load;

	reg  [12:0] cnt_ff;
	reg  [12:0] nxt_cnt;
	reg  [3:0]  ovs_ff;
	reg  [3:0]  nxt_ovs;
	reg         armed_ff;
	reg         nxt_tick;
	reg         nxt_bit;
	reg  [7:0]  nxt_rdata;
	wire        run;

	ubd_regfile u_regs
	(
		.i_clk         (I_CORE_CLK),
		.i_rst_n       (I_RST_N),
		.i_wr          (I_WR),
		.i_addr        (I_ADDR),
		.i_wdata       (I_WDATA),
		.o_high_buf_ff (high_buf),
		.o_divisor_ff  (divisor),
		.o_ctrl_ff     (ctrl),
		.o_load_ff     (load)
	);

	// R6 - arm on first enable
	// Sticks once set, so later disables keep the divider coherent
	always @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			armed_ff <= 1'b0;
		else if (ctrl[`UBD_CTRL_RX_ON] | ctrl[`UBD_CTRL_TX_ON])
			armed_ff <= 1'b1;
	end

	// R4 - zero divisor stops
	assign run = armed_ff & (divisor != 13'h0000);

	// R7 - modulo count, reload
	// R5 - sixteen ticks per bit
	always @*
	begin
		nxt_cnt  = cnt_ff;
		nxt_ovs  = ovs_ff;
		nxt_tick = 1'b0;
		nxt_bit  = 1'b0;
		if (!run || load)
		begin
			nxt_cnt = 13'h0001;
			nxt_ovs = 4'h0;
		end
		else if (cnt_ff >= divisor)
		begin
			nxt_cnt  = 13'h0001;
			nxt_tick = 1'b1;
			nxt_ovs  = ovs_ff + 4'h1;
			nxt_bit  = (ovs_ff == 4'hf);
		end
		else
			nxt_cnt = cnt_ff + 13'h0001;
	end

	always @*
	begin
		case (I_ADDR)
			`UBD_OFF_DIV_HIGH: nxt_rdata = {3'h0, high_buf};
			`UBD_OFF_DIV_LOW:  nxt_rdata = divisor[7:0];
			`UBD_OFF_CTRL:     nxt_rdata = ctrl;
			`UBD_OFF_STATUS:   nxt_rdata = {6'h00, armed_ff, run};
			default:           nxt_rdata = 8'h00;
		endcase
	end

	always @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			cnt_ff     <= 13'h0001;
			ovs_ff     <= 4'h0;
			O_TICK16   <= 1'b0;
			O_BIT_TICK <= 1'b0;
			O_RDATA    <= 8'h00;
			O_RX_ON    <= 1'b0;
			O_TX_ON    <= 1'b0;
		end
		else
		begin
			cnt_ff     <= nxt_cnt;
			ovs_ff     <= nxt_ovs;
			O_TICK16   <= nxt_tick;
			O_BIT_TICK <= nxt_bit;
			O_RDATA    <= I_RD ? nxt_rdata : 8'h00;
			O_RX_ON    <= ctrl[`UBD_CTRL_RX_ON];
			O_TX_ON    <= ctrl[`UBD_CTRL_TX_ON];
		end
	end

endmodule // ubd_baud_gen

// ---- shared/ubd_defs.vh ----
`ifndef UBD_DEFS_VH
`define UBD_DEFS_VH

// Register offsets on the plain register port
`define UBD_ADDR_W          4
`define UBD_OFF_DIV_HIGH    4'h0
`define UBD_OFF_DIV_LOW     4'h1
`define UBD_OFF_CTRL        4'h2
`define UBD_OFF_STATUS      4'h3

// Field positions
`define UBD_DIV_W           13
`define UBD_HIGH_BITS       5
`define UBD_CTRL_RX_ON      0
`define UBD_CTRL_TX_ON      1
`define UBD_STAT_RUN        0
`define UBD_STAT_ARMED      1

// Reset values
`define UBD_RST_DIV_HIGH    8'h00
`define UBD_RST_DIV_LOW     8'h04
`define UBD_RST_CTRL        8'h00

// Oversampling: one bit time is this many ticks
`define UBD_OVERSAMPLE      5'h10
`define UBD_OVS_W           4

`endif

// ---- verilog/ubd_regfile.v ----
`timescale 1ns/1ps
`include "ubd_defs.vh"

// Register store for the divisor halves and control bits
module ubd_regfile
(
	input  wire                   i_clk,
	input  wire                   i_rst_n,
	input  wire                   i_wr,
	input  wire [`UBD_ADDR_W-1:0] i_addr,
	input  wire [7:0]             i_wdata,
	output reg  [4:0]             o_high_buf_ff,
	output reg  [12:0]            o_divisor_ff,
	output reg  [7:0]             o_ctrl_ff,
	output reg                    o_load_ff
);

	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_high_buf_ff <= 5'h00;
			o_divisor_ff  <= {5'h00, `UBD_RST_DIV_LOW};
			o_ctrl_ff     <= `UBD_RST_CTRL;
			o_load_ff     <= 1'b0;
		end
		else
		begin
			o_load_ff <= 1'b0;
			if (i_wr)
			begin
				case (i_addr)
					// R2 - high only buffers
					`UBD_OFF_DIV_HIGH:
						o_high_buf_ff <= i_wdata[4:0];
					// R2 - low commits buffer
					`UBD_OFF_DIV_LOW:
					begin
						// R3 - upper/lower assembly
						o_divisor_ff <= {o_high_buf_ff, i_wdata};
						o_load_ff    <= 1'b1;
					end
					`UBD_OFF_CTRL:
						o_ctrl_ff <= {6'h00, i_wdata[1:0]};
					default:
						o_load_ff <= 1'b0;
				endcase
			end
		end
	end

endmodule // ubd_regfile

// ---- dv/ubd_chk_sva.sv ----
`timescale 1ns/1ps
module ubd_chk
(
	input wire       I_CORE_CLK,
	input wire       I_RST_N,
	input wire [3:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire       I_WR,
	input wire       I_RD,
	input wire [7:0] O_RDATA,
	input wire       O_TICK16,
	input wire       O_BIT_TICK,
	input wire       O_RX_ON,
	input wire       O_TX_ON
);
	logic [4:0]  hb_ff;
	logic [12:0] div_ff;
	logic        arm_ff;
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
		if (!I_RST_N)
			{arm_ff, hb_ff, div_ff} <= 19'h4;
		else
		begin
			arm_ff <= arm_ff | O_RX_ON | O_TX_ON;
			hb_ff  <= (I_WR && I_ADDR == 4'h0) ? I_WDATA[4:0] : hb_ff;
			div_ff <= (I_WR && I_ADDR == 4'h1) ? {hb_ff, I_WDATA} : div_ff;
		end
	sequence s_fast;
		O_TICK16 && div_ff == 13'h1;
	endsequence
	idle_tick_a: assert property (!arm_ff && !O_RX_ON && !O_TX_ON |-> !O_TICK16)
		else $error("tick while idle");
	zero_stop_a: assert property ((div_ff == 13'h0) [*2] |-> !O_TICK16)
		else $error("tick at zero divisor");
	fast_tick_a: assert property (s_fast ##1 div_ff == 13'h1 |-> O_TICK16)
		else $error("divisor one missed a tick");
	high_read_a: assert property (I_RD && I_ADDR == 4'h0 |=> O_RDATA == {3'h0, $past(hb_ff)})
		else $error("high read not buffer");
	low_read_a: assert property (I_RD && I_ADDR == 4'h1 |=> O_RDATA == $past(div_ff[7:0]))
		else $error("low read wrong");
	bit_on_tick_a: assert property (O_BIT_TICK |-> O_TICK16)
		else $error("bit tick without tick");
endmodule // ubd_chk

// ---- dv/ubd_baud_gen_bench.sv ----
`timescale 1ns/1ps
module ubd_baud_gen_bench;
	logic       clk = 0;
	logic       rst_n = 0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 0;
	logic       rd = 0;
	logic [7:0] rdata;
	logic       tick16;
	logic       bit_tick;
	logic       rx_on;
	logic       tx_on;
	int         err_count = 0;
	int         check_count = 0;
	int         cyc = 0;
	ubd_baud_gen u_ubd_baud_gen
	(
		.I_CORE_CLK (clk),
		.I_RST_N    (rst_n),
		.I_ADDR     (addr),
		.I_WDATA    (wdata),
		.I_WR       (wr),
		.I_RD       (rd),
		.O_RDATA    (rdata),
		.O_TICK16   (tick16),
		.O_BIT_TICK (bit_tick),
		.O_RX_ON    (rx_on),
		.O_TX_ON    (tx_on)
	);
	initial forever #2 clk = ~clk;
	task close_out;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input [15:0] g, input [15:0] e);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wrr(input [3:0] a, input [7:0] d);
		@(posedge clk);
		{addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge clk);
		wr <= 0;
	endtask
	task rdc(input [3:0] a, input [7:0] e);
		@(posedge clk);
		{addr, rd} <= {a, 1'b1};
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	// Third gap only: the first two may straddle a divisor reload
	task gap(input b, input [15:0] e);
		int n;
		repeat (3)
		begin
			n = 0;
			do
			begin
				@(negedge clk);
				n++;
			end
			while ((b ? bit_tick : tick16) !== 1 && n < 5000);
		end
		chk(n[15:0], e);
	endtask
	// The edge that takes a divisor write still ticks with the old divisor
	task quiet;
		int n;
		n = 0;
		@(posedge clk);
		repeat (60) @(negedge clk) if (tick16 !== 1'b0) n++;
		chk(n[15:0], 0);
	endtask
	task t_reset;
		rdc(4'h1, 8'h04);
		rdc(4'h9, 8'h00);
		rdc(4'h3, 8'h00);
		quiet;
		$display("reset test done");
	endtask
	task t_rate;
		wrr(4'h2, 8'h01);
		gap(0, 4);
		chk({tx_on, rx_on}, 1);
		rdc(4'h3, 8'h03);
		gap(1, 64);
		$display("rate test done");
	endtask
	task t_buffer;
		wrr(4'h0, 8'h01);
		rdc(4'h0, 8'h01);
		rdc(4'h1, 8'h04);
		gap(0, 4);
		wrr(4'h1, 8'h00);
		gap(0, 256);
		$display("buffer test done");
	endtask
	task t_fast_zero;
		wrr(4'h0, 8'h00);
		wrr(4'h1, 8'h01);
		gap(0, 1);
		gap(1, 16);
		wrr(4'h1, 8'h00);
		quiet;
		rdc(4'h3, 8'h02);
		$display("fast and zero test done");
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			close_out;
		end
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		t_reset;
		t_rate;
		t_buffer;
		t_fast_zero;
		close_out;
	end
endmodule // ubd_baud_gen_bench
bind ubd_baud_gen ubd_chk u_ubd_chk (.I_CORE_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
	.O_TICK16, .O_BIT_TICK, .O_RX_ON, .O_TX_ON);
